//--- verilog/tlic_pkg.sv
`default_nettype none

package tlic_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int PC_W   = 21;
    localparam int ADDR_W = 8;
    localparam int NEXT_W = 3;

    // ------------------------------------------------------------
    // vector addresses
    // ------------------------------------------------------------
    localparam logic [PC_W-1:0] VEC_HIGH = 21'h000008;
    localparam logic [PC_W-1:0] VEC_LOW  = 21'h000018;

    // ------------------------------------------------------------
    // register map, byte addresses
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_CTRL  = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_FLAG  = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_EN    = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_PRIO  = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_STATE = 8'h10;

    // ------------------------------------------------------------
    // control register layout
    // ------------------------------------------------------------
    typedef struct packed {
        logic [NEXT_W-1:0] ext_pin_edge_select;
        logic              low_level_global_enable;
        logic              high_level_global_enable;
        logic              priority_mode_select;
    } tlic_ctrl_t;

    localparam int          CTRL_W   = 6;
    localparam logic [5:0]  CTRL_RST = 6'h38;

    // ------------------------------------------------------------
    // request pipeline stages between pin event and vector
    // ------------------------------------------------------------
    localparam int LAT_STAGES = 2;

    // ------------------------------------------------------------
    // vector request to the program sequencer
    // ------------------------------------------------------------
    typedef struct packed {
        logic            valid;
        logic            high;
        logic [PC_W-1:0] target;
        logic [PC_W-1:0] ret;
    } tlic_vec_t;

endpackage : tlic_pkg

`default_nettype wire

//--- verilog/tlic_edge_det.sv
`timescale 1ns/1ps
`default_nettype none

module tlic_edge_det #(
    parameter int NPIN = 3
) (
    input  wire logic            clk_in,
    input  wire logic            rst_in,
    input  wire logic            tick_in,
    input  wire logic [NPIN-1:0] pin_in,
    input  wire logic [NPIN-1:0] edge_sel_in,
    output logic      [NPIN-1:0] event_out
);

    logic [NPIN-1:0] prev;
    logic [NPIN-1:0] next_prev;

    // pins are looked at once per instruction cycle
    genvar g;
    generate
        for (g = 0; g < NPIN; g++) begin : g_pin
            always_comb begin
                next_prev[g] = tick_in ? pin_in[g] : prev[g];
                // one selects rising, zero falling  [RQ17]
                event_out[g] = tick_in && (pin_in[g] != prev[g])
                               && (pin_in[g] == edge_sel_in[g]);
            end
        end
    endgenerate

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            // track the pin in reset so an idle-high pin gives no false edge
            prev <= pin_in;
        end else begin
            prev <= next_prev;
        end
    end

endmodule : tlic_edge_det

`default_nettype wire

//--- verilog/tlic_irq_ctrl.sv
// Overview of operation
// RQ1 - high vector 0008h, low vector 0018h
// RQ2 - high request preempts running low routine
// RQ3 - each source: flag, enable, priority bit
// RQ4 - priority mode: bit7 high, bit6 low enable; code: ctrl bit1 high, bit2 low enable
// RQ5 - flag, enable, level enable set: vector
// RQ6 - compatibility mode: priority ignored, vector 0008h
// RQ7 - compatibility: bit6 peripherals, bit7 all sources; code: ctrl bit2 peripherals, bit1 all sources
// RQ8 - taking clears the admitting global enable
// RQ9 - no low request during high routine
// RQ10 - push return address, load vector
// RQ11 - software clears flags before re-enabling
// RQ12 - return restores the cleared global enable
// RQ13 - pin event to vector: three-four cycles
// RQ14 - flags set regardless of any enable
// RQ15 - software avoids memory moves on live controls
// RQ16 - low enable gates low peripheral sources
// RQ17 - per-pin edge select: one rising
// RQ18 - high request wins over simultaneous low
// RQ19 - push, load, clear in one step
`timescale 1ns/1ps
`default_nettype none

module tlic_irq_ctrl #(
    parameter int               NSRC        = 8,
    parameter int               NEXT        = 3,
    parameter logic [NSRC-1:0]  PERIPH_MASK = 8'hf8
) (
    input  wire logic                         clk_in,
    input  wire logic                         rst_in,
    input  wire logic                         hsel_in,
    input  wire logic [31:0]                  haddr_in,
    input  wire logic [1:0]                   htrans_in,
    input  wire logic                         hwrite_in,
    input  wire logic [2:0]                   hsize_in,
    input  wire logic [31:0]                  hwdata_in,
    input  wire logic                         hready_in,
    output logic                              hreadyout_out,
    output logic                              hresp_out,
    output logic [31:0]                       hrdata_out,
    input  wire logic                         instr_tick_in,
    input  wire logic [NEXT-1:0]              external_irq_pin_in,
    input  wire logic [NSRC-NEXT-1:0]         periph_event_in,
    input  wire logic                         interrupt_return_instr_in,
    input  wire logic [tlic_pkg::PC_W-1:0]    pc_in,
    output tlic_pkg::tlic_vec_t               vector_out,
    output logic                              irq_out
);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    generate
        if (NEXT < 1 || NEXT > tlic_pkg::NEXT_W || NSRC <= NEXT || NSRC > 32) begin : g_bad
            $error("tlic_irq_ctrl: unsupported source counts");
        end
    endgenerate

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    tlic_pkg::tlic_ctrl_t ctrl, next_ctrl;
    logic [NSRC-1:0]      flag, next_flag;
    logic [NSRC-1:0]      en, next_en;
    logic [NSRC-1:0]      prio, next_prio;
    logic                 hp_active, next_hp_active;
    logic                 lp_active, next_lp_active;
    logic [tlic_pkg::LAT_STAGES-1:0] req_pipe, next_req_pipe;
    tlic_pkg::tlic_vec_t  next_vector;
    logic                 next_irq;

    logic                        dp_valid, next_dp_valid;
    logic                        dp_write, next_dp_write;
    logic [tlic_pkg::ADDR_W-1:0] dp_addr, next_dp_addr;
    logic                        next_hreadyout;
    logic [31:0]                 next_hrdata;

    logic [NEXT-1:0] ext_event;
    logic [NSRC-1:0] set_vec;
    logic [NSRC-1:0] active;
    logic            elig_hi;
    logic            elig_lo;
    logic            take;
    logic            take_high;
    logic            wr_ctrl;
    logic            wr_flag;
    logic            wr_en;
    logic            wr_prio;

    // ------------------------------------------------------------
    // pin edge detection
    // ------------------------------------------------------------
    tlic_edge_det #(
        .NPIN (NEXT)
    ) u_edge (
        .clk_in      (clk_in),
        .rst_in      (rst_in),
        .tick_in     (instr_tick_in),
        .pin_in      (external_irq_pin_in),
        .edge_sel_in (ctrl.ext_pin_edge_select[NEXT-1:0]),
        .event_out   (ext_event)
    );

    // ------------------------------------------------------------
    // request arbitration
    // ------------------------------------------------------------
    always_comb begin
        set_vec = {periph_event_in, ext_event};
        active  = flag & en;                                          // [RQ3]
        if (ctrl.priority_mode_select) begin
            elig_hi = ctrl.high_level_global_enable && |(active & prio);   // [RQ4] [RQ5]
            // low level needs its own enable and no high routine running
            elig_lo = ctrl.high_level_global_enable && ctrl.low_level_global_enable
                      && !hp_active && |(active & ~prio);             // [RQ9] [RQ16]
        end else begin
            // priority bits have no effect here
            elig_hi = ctrl.high_level_global_enable
                      && |(active & (~PERIPH_MASK
                           | {NSRC{ctrl.low_level_global_enable}}));  // [RQ6] [RQ7]
            elig_lo = 1'b0;
        end
        // pipeline gives a fixed latency in instruction cycles, so the length
        // of the interrupted instruction plays no part
        take      = instr_tick_in && req_pipe[tlic_pkg::LAT_STAGES-1]
                    && (elig_hi || elig_lo);                           // [RQ13]
        take_high = elig_hi;                                          // [RQ18] [RQ2]
    end

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    always_comb begin
        wr_ctrl = dp_valid && dp_write && (dp_addr == tlic_pkg::OFF_CTRL);
        wr_flag = dp_valid && dp_write && (dp_addr == tlic_pkg::OFF_FLAG);
        wr_en   = dp_valid && dp_write && (dp_addr == tlic_pkg::OFF_EN);
        wr_prio = dp_valid && dp_write && (dp_addr == tlic_pkg::OFF_PRIO);
    end

    // ------------------------------------------------------------
    // controller next state
    // ------------------------------------------------------------
    always_comb begin
        next_ctrl      = ctrl;
        next_en        = wr_en ? hwdata_in[NSRC-1:0] : en;
        next_prio      = wr_prio ? hwdata_in[NSRC-1:0] : prio;
        next_hp_active = hp_active;
        next_lp_active = lp_active;
        if (wr_ctrl) begin
            next_ctrl = tlic_pkg::tlic_ctrl_t'(hwdata_in[tlic_pkg::CTRL_W-1:0]);
        end
        // set wins over the write-one clear  [RQ14]
        next_flag = (wr_flag ? (flag & ~hwdata_in[NSRC-1:0]) : flag) | set_vec;
        if (interrupt_return_instr_in) begin                          // [RQ12]
            if (hp_active) begin
                next_ctrl.high_level_global_enable = 1'b1;
                next_hp_active                     = 1'b0;
            end else if (lp_active) begin
                next_ctrl.low_level_global_enable = 1'b1;
                next_lp_active                    = 1'b0;
            end
        end
        // hardware clear overrides a software write in the same cycle
        if (take) begin                                               // [RQ19]
            if (take_high) begin
                next_ctrl.high_level_global_enable = 1'b0;            // [RQ8]
                next_hp_active                     = 1'b1;
            end else begin
                next_ctrl.low_level_global_enable = 1'b0;             // [RQ8]
                next_lp_active                    = 1'b1;
            end
        end
        next_req_pipe = req_pipe;
        if (instr_tick_in) begin
            next_req_pipe = {req_pipe[tlic_pkg::LAT_STAGES-2:0], elig_hi || elig_lo};
        end
        next_vector       = '0;
        next_vector.valid = take;                                     // [RQ10] [RQ19]
        next_vector.high  = take_high;
        next_vector.target = take_high ? tlic_pkg::VEC_HIGH : tlic_pkg::VEC_LOW;  // [RQ1]
        next_vector.ret   = pc_in;
        next_irq          = |(flag & en);
    end

    // ------------------------------------------------------------
    // bus slave next state: one wait state per transfer
    // ------------------------------------------------------------
    always_comb begin
        next_dp_valid  = 1'b0;
        next_dp_write  = dp_write;
        next_dp_addr   = dp_addr;
        next_hreadyout = 1'b1;
        next_hrdata    = hrdata_out;
        if (dp_valid) begin
            // writes of the data phase land before the read value is taken
            next_hrdata = 32'h00000000;
            if (!dp_write) begin
                case (dp_addr)
                    tlic_pkg::OFF_CTRL:  next_hrdata[tlic_pkg::CTRL_W-1:0] = ctrl;
                    tlic_pkg::OFF_FLAG:  next_hrdata[NSRC-1:0] = flag;
                    tlic_pkg::OFF_EN:    next_hrdata[NSRC-1:0] = en;
                    tlic_pkg::OFF_PRIO:  next_hrdata[NSRC-1:0] = prio;
                    tlic_pkg::OFF_STATE: next_hrdata[2:0] = {irq_out, lp_active, hp_active};
                    default:             next_hrdata = 32'h00000000;
                endcase
            end
        end else if (hsel_in && htrans_in[1] && hready_in) begin
            next_dp_valid  = 1'b1;
            next_dp_write  = hwrite_in;
            next_dp_addr   = haddr_in[tlic_pkg::ADDR_W-1:0];
            next_hreadyout = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ctrl          <= tlic_pkg::tlic_ctrl_t'(tlic_pkg::CTRL_RST);
            flag          <= '0;
            en            <= '0;
            prio          <= '1;
            hp_active     <= 1'b0;
            lp_active     <= 1'b0;
            req_pipe      <= '0;
            vector_out    <= '0;
            irq_out       <= 1'b0;
            dp_valid      <= 1'b0;
            dp_write      <= 1'b0;
            dp_addr       <= '0;
            hreadyout_out <= 1'b1;
            hresp_out     <= 1'b0;
            hrdata_out    <= 32'h00000000;
        end else begin
            ctrl          <= next_ctrl;
            flag          <= next_flag;
            en            <= next_en;
            prio          <= next_prio;
            hp_active     <= next_hp_active;
            lp_active     <= next_lp_active;
            req_pipe      <= next_req_pipe;
            vector_out    <= next_vector;
            irq_out       <= next_irq;
            dp_valid      <= next_dp_valid;
            dp_write      <= next_dp_write;
            dp_addr       <= next_dp_addr;
            hreadyout_out <= next_hreadyout;
            hresp_out     <= 1'b0;
            hrdata_out    <= next_hrdata;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    property p_vec_addr;
        vector_out.valid |-> vector_out.target ==
            (vector_out.high ? tlic_pkg::VEC_HIGH : tlic_pkg::VEC_LOW);
    endproperty
    a_vec_addr: assert property (p_vec_addr) else $error("wrong vector address"); // [RQ1]

    property p_compat_vec;
        take && !ctrl.priority_mode_select |=> vector_out.target == tlic_pkg::VEC_HIGH;
    endproperty
    a_compat_vec: assert property (p_compat_vec) else $error("compat not at 0008h"); // [RQ6]

    property p_clear_low;
        take && !take_high |=> !ctrl.low_level_global_enable && lp_active;
    endproperty
    a_clear_low: assert property (p_clear_low) else $error("low enable not cleared"); // [RQ8]
    property p_clear_high;
        take && take_high |=> !ctrl.high_level_global_enable && hp_active;
    endproperty
    a_clear_high: assert property (p_clear_high) else $error("enable not cleared"); // [RQ8]

    property p_low_blocked;
        hp_active |-> !(take && !take_high);
    endproperty
    a_low_blocked: assert property (p_low_blocked) else $error("low taken in high"); // [RQ9]

    property p_push;
        take |=> vector_out.valid && vector_out.ret == $past(pc_in);
    endproperty
    a_push: assert property (p_push) else $error("return address not pushed"); // [RQ10]

    property p_flag_set;
        set_vec[0] |=> flag[0];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("event flag lost"); // [RQ14]

    property p_return_high;
        interrupt_return_instr_in && hp_active && !take |=>
            ctrl.high_level_global_enable && !hp_active;
    endproperty
    a_return_high: assert property (p_return_high) else $error("return did not restore"); // [RQ12]

    property p_high_first;
        take && elig_hi && elig_lo |=> vector_out.high;
    endproperty
    a_high_first: assert property (p_high_first) else $error("low beat high"); // [RQ18]

    property p_preempt;
        take && lp_active && elig_hi |=> hp_active && lp_active;
    endproperty
    a_preempt: assert property (p_preempt) else $error("preemption failed"); // [RQ2]

    property p_no_early;
        vector_out.valid |-> $past(req_pipe[tlic_pkg::LAT_STAGES-1]);
    endproperty
    a_no_early: assert property (p_no_early) else $error("vector before latency"); // [RQ13]

    c_high_take: cover property (take && take_high);
    c_low_take:  cover property (take && !take_high);
    c_preempt:   cover property (take && take_high && lp_active);
    c_return:    cover property (interrupt_return_instr_in && hp_active);

endmodule : tlic_irq_ctrl

`default_nettype wire

//--- tb/tlic_core_model.sv
`timescale 1ns/1ps
`default_nettype none

module tlic_core_model #(
    parameter int TICK_DIV = 4
) (
    input  wire logic                clk_in,
    input  wire logic                rst_in,
    input  wire tlic_pkg::tlic_vec_t vec_in,
    input  wire logic                ret_req_in,
    output logic                     tick_out,
    output logic [20:0]              pc_out,
    output logic                     ret_out,
    output logic [7:0]               n_vec_out,
    output logic [3:0]               depth_out
);
    // ------------------------------------------------------------
    // sequencer: instruction ticks, pc, hardware stack
    // ------------------------------------------------------------
    logic [3:0]  div;
    logic [20:0] stack [0:7];

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            div       <= 4'h0;
            tick_out  <= 1'b0;
            pc_out    <= 21'h000100;
            ret_out   <= 1'b0;
            n_vec_out <= 8'h00;
            depth_out <= 4'h0;
        end else begin
            div      <= (div == 4'(TICK_DIV - 1)) ? 4'h0 : div + 4'h1;
            tick_out <= (div == 4'(TICK_DIV - 1));
            ret_out  <= ret_req_in;
            if (vec_in.valid) begin
                // push and jump in one step, as the core must
                stack[depth_out[2:0]] <= vec_in.ret;
                depth_out             <= depth_out + 4'h1;
                pc_out                <= vec_in.target;
                n_vec_out             <= n_vec_out + 8'h01;
            end else if (ret_out) begin
                depth_out <= depth_out - 4'h1;
                pc_out    <= stack[depth_out[2:0] - 3'h1];
            end else if (tick_out) begin
                pc_out <= pc_out + 21'h000001;
            end
        end
    end
endmodule : tlic_core_model

`default_nettype wire

//--- tb/two_level_interrupt_controller_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module two_level_interrupt_controller_tb_top;
    logic                clk     = 1'b0;
    logic                rst     = 1'b1;
    logic                hsel    = 1'b0;
    logic [31:0]         haddr   = 32'h0;
    logic [1:0]          htrans  = 2'b00;
    logic                hwrite  = 1'b0;
    logic [2:0]          hsize   = 3'h2;
    logic [31:0]         hwdata  = 32'h0;
    logic                ret_req = 1'b0;
    logic [2:0]          pins    = 3'h0;
    logic [4:0]          periph  = 5'h00;
    wire logic           hrdy;
    wire logic           hresp;
    wire logic [31:0]    hrdata;
    wire logic           tick;
    wire logic [20:0]    pc;
    wire logic           ret_pulse;
    wire logic           irq;
    wire logic [7:0]     n_vec;
    wire logic [3:0]     depth;
    tlic_pkg::tlic_vec_t vec;
    int                  n_fail   = 0;
    int                  n_checks = 0;
    logic [31:0]         d;
    int                  nt;

    always #25 clk = ~clk;

    tlic_irq_ctrl dut (.clk_in(clk), .rst_in(rst), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
        .hready_in(hrdy), .hreadyout_out(hrdy), .hresp_out(hresp), .hrdata_out(hrdata),
        .instr_tick_in(tick), .external_irq_pin_in(pins), .periph_event_in(periph),
        .interrupt_return_instr_in(ret_pulse), .pc_in(pc), .vector_out(vec), .irq_out(irq));

    tlic_core_model core (.clk_in(clk), .rst_in(rst), .vec_in(vec), .ret_req_in(ret_req),
        .tick_out(tick), .pc_out(pc), .ret_out(ret_pulse), .n_vec_out(n_vec),
        .depth_out(depth));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    // single word transfer; every change lands just after a rising edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int k;
        k = 0;
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {24'h000000, a};
        hwrite <= wr;
        @(posedge clk);
        while (hrdy !== 1'b1 && k < 50) begin @(posedge clk); k++; end
        htrans <= 2'b00;
        hsel   <= 1'b0;
        hwdata <= wd;
        @(posedge clk);
        while (hrdy !== 1'b1 && k < 50) begin @(posedge clk); k++; end
        d = hrdata;
        chk("bus wait", 32'h1, 32'(k < 50));
        chk("hresp", 32'h0, 32'(hresp));
    endtask : bus

    task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(what, exp, d);
    endtask : rd

    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clk);
            while (tick !== 1'b1) @(posedge clk);
        end
    endtask : ticks

    task automatic no_vec();
        logic [7:0] v;
        v = n_vec;
        ticks(8);
        chk("vector count", 32'(v), 32'(n_vec));
    endtask : no_vec

    task automatic wait_vec(input logic [20:0] tgt, input logic hi);
        logic [20:0] pc_t;
        int          k;
        k    = 0;
        nt   = 0;
        pc_t = pc;
        @(posedge clk);
        while (vec.valid !== 1'b1 && k < 400) begin
            if (tick === 1'b1) begin nt++; pc_t = pc; end
            @(posedge clk);
            k++;
        end
        chk("vector target", 32'(tgt), 32'(vec.target));
        chk("vector level", 32'(hi), 32'(vec.high));
        if (nt > 0) chk("return address", 32'(pc_t), 32'(vec.ret));
    endtask : wait_vec

    task automatic do_ret();
        ret_req <= 1'b1;
        @(posedge clk);
        ret_req <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : do_ret

    task automatic pulse3();
        periph <= 5'h01;
        @(posedge clk);
        periph <= 5'h00;
    endtask : pulse3

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rd("ctrl reset", tlic_pkg::OFF_CTRL, 32'h38);
        rd("flag reset", tlic_pkg::OFF_FLAG, 32'h0);
        rd("en reset", tlic_pkg::OFF_EN, 32'h0);
        rd("prio reset", tlic_pkg::OFF_PRIO, 32'hff);
        rd("state reset", tlic_pkg::OFF_STATE, 32'h0);
        bus(1'b1, 8'h20, 32'h5a5a5a5a);
        rd("unmapped", 8'h20, 32'h0);
    endtask : t_reset

    task automatic t_poll();
        bus(1'b1, tlic_pkg::OFF_CTRL, 32'h00);
        ticks(1);
        pins <= 3'h1;
        ticks(3);
        rd("flag rise ignored", tlic_pkg::OFF_FLAG, 32'h0);
        pins <= 3'h0;
        ticks(3);
        rd("flag on fall", tlic_pkg::OFF_FLAG, 32'h01);
        chk("irq masked", 32'h0, 32'(irq));
        bus(1'b1, tlic_pkg::OFF_EN, 32'h01);
        repeat (2) @(posedge clk);
        chk("irq raised", 32'h1, 32'(irq));
        bus(1'b1, tlic_pkg::OFF_FLAG, 32'h01);
        repeat (2) @(posedge clk);
        chk("irq cleared", 32'h0, 32'(irq));
        rd("flag w1c", tlic_pkg::OFF_FLAG, 32'h0);
        chk("no vector", 32'h0, 32'(n_vec));
        bus(1'b1, tlic_pkg::OFF_CTRL, 32'h38);
    endtask : t_poll

    task automatic t_compat();
        bus(1'b1, tlic_pkg::OFF_CTRL, 32'h3a);
        bus(1'b1, tlic_pkg::OFF_EN, 32'hff);
        bus(1'b1, tlic_pkg::OFF_PRIO, 32'h00);
        pulse3();
        no_vec();
        rd("periph flag", tlic_pkg::OFF_FLAG, 32'h08);
        ticks(1);
        pins <= 3'h1;
        wait_vec(tlic_pkg::VEC_HIGH, 1'b1);
        chk("latency ok", 32'h1, 32'(nt >= 3 && nt <= 4));
        rd("enable cleared", tlic_pkg::OFF_CTRL, 32'h38);
        bus(1'b1, tlic_pkg::OFF_FLAG, 32'h01);
        do_ret();
        rd("enable restored", tlic_pkg::OFF_CTRL, 32'h3a);
        bus(1'b1, tlic_pkg::OFF_CTRL, 32'h3e);
        wait_vec(tlic_pkg::VEC_HIGH, 1'b1);
        rd("enable cleared", tlic_pkg::OFF_CTRL, 32'h3c);
        bus(1'b1, tlic_pkg::OFF_FLAG, 32'h08);
        do_ret();
        rd("enable restored", tlic_pkg::OFF_CTRL, 32'h3e);
        chk("stack empty", 32'h0, 32'(depth));
        pins <= 3'h0;
        bus(1'b1, tlic_pkg::OFF_CTRL, 32'h38);
    endtask : t_compat

    task automatic t_prio();
        bus(1'b1, tlic_pkg::OFF_PRIO, 32'h01);
        bus(1'b1, tlic_pkg::OFF_CTRL, 32'h39);
        ticks(1);
        pins <= 3'h1;
        pulse3();
        no_vec();
        rd("both flags", tlic_pkg::OFF_FLAG, 32'h09);
        bus(1'b1, tlic_pkg::OFF_CTRL, 32'h3f);
        wait_vec(tlic_pkg::VEC_HIGH, 1'b1);
        rd("high cleared", tlic_pkg::OFF_CTRL, 32'h3d);
        rd("high active", tlic_pkg::OFF_STATE, 32'h5);
        no_vec();
        bus(1'b1, tlic_pkg::OFF_FLAG, 32'h01);
        do_ret();
        wait_vec(tlic_pkg::VEC_LOW, 1'b0);
        rd("low cleared", tlic_pkg::OFF_CTRL, 32'h3b);
        pins <= 3'h0;
        ticks(2);
        pins <= 3'h1;
        wait_vec(tlic_pkg::VEC_HIGH, 1'b1);
        rd("both cleared", tlic_pkg::OFF_CTRL, 32'h39);
        chk("stack depth", 32'h2, 32'(depth));
        bus(1'b1, tlic_pkg::OFF_FLAG, 32'h01);
        do_ret();
        rd("high restored", tlic_pkg::OFF_CTRL, 32'h3b);
        bus(1'b1, tlic_pkg::OFF_FLAG, 32'h08);
        do_ret();
        rd("low restored", tlic_pkg::OFF_CTRL, 32'h3f);
        no_vec();
        chk("stack empty", 32'h0, 32'(depth));
    endtask : t_prio

    // ------------------------------------------------------------
    // run and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_poll();
        t_compat();
        t_prio();
        tally_and_finish();
    end

    // about 400 cycles expected; fifteen times that before giving up
    initial begin
        #300000;
        n_fail++;
        tally_and_finish();
    end
endmodule : two_level_interrupt_controller_tb_top

`default_nettype wire
